//--- enc_zscale_consts.svh
// offsets, field positions, reset values and limits of the encoder command block
`ifndef ENC_ZSCALE_CONSTS_SVH
`define ENC_ZSCALE_CONSTS_SVH

// ********************
// register byte offsets
// ********************
`define ADDR_CMD 8'h00
`define ADDR_CFG_A 8'h04
`define ADDR_CFG_B 8'h08
`define ADDR_MULT_A 8'h0c
`define ADDR_MULT_B 8'h10
`define ADDR_OFS_HI 8'h14
`define ADDR_OFS_A 8'h18
`define ADDR_OFS_B 8'h1c
`define ADDR_SCL_A_LO 8'h20
`define ADDR_SCL_A_HI 8'h24
`define ADDR_SCL_B_LO 8'h28
`define ADDR_SCL_B_HI 8'h2c
`define ADDR_ZMODE_A 8'h30
`define ADDR_ZMODE_B 8'h34
`define ADDR_SET_A 8'h38
`define ADDR_SET_B 8'h3c

// ********************
// field positions
// ********************
`define CMD_OP_LSB 0
`define CMD_OP_MSB 1
`define CMD_CHAN_BIT 2
`define CMD_EDGE_BIT 3
`define CFG_MULT_LSB 0
`define CFG_MULT_MSB 1
`define CFG_DIR_BIT 2
`define OFS_HI_SIGN_BIT 2

// ********************
// reset values and limits
// ********************
`define MULT_RESET 32'sd1000000
`define MULT_MAX 33'd999999999
`define MULT_MIN 33'd1
`define OFS_RESET 32'sh00000000
`define OFS_MAX 34'h07fffffff
`define CFG_RESET 3'h0
`define EDGE_RISE_RESET 1'b1

// ********************
// ascii reply characters
// ********************
`define CHR_Z 8'h5a
`define CHR_A 8'h41
`define CHR_B 8'h42
`define CHR_C 8'h43
`define CHR_N 8'h4e
`define CHR_U 8'h55
`define CHR_D 8'h44
`define CHR_F 8'h46
`define CHR_R 8'h52
`define CHR_1 8'h31
`define CHR_2 8'h32
`define CHR_4 8'h34

`endif

//--- enc_zscale_pkg.sv
// types shared by the encoder index-clear and scaling block
package enc_zscale_pkg;

	// operation field of a write to the command register
	typedef enum logic [1:0] {
		OP_ARM = 2'h0,
		OP_CANCEL = 2'h1,
		OP_EDGE = 2'h2,
		OP_NONE = 2'h3
	} index_op_t;

	// edge multiplication code of a channel setting
	typedef enum logic [1:0] {
		EDGE_X1 = 2'h0,
		EDGE_X2 = 2'h1,
		EDGE_X4 = 2'h2,
		EDGE_XR = 2'h3
	} edge_mult_t;

	typedef logic signed [31:0] mult_t;
	typedef logic signed [31:0] ofs_t;
	typedef logic signed [63:0] scaled_t;

endpackage

//--- enc_zscale.sv
// index clear, channel settings and scaling for two encoder channels
`include "enc_zscale_consts.svh"

module enc_zscale
	import enc_zscale_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	// raw counts from the encoder counters
	input wire logic signed [31:0] count_a,
	input wire logic signed [31:0] count_b,
	// index inputs
	input wire logic index_a,
	input wire logic index_b,
	// counter clear pulses
	output logic clear_a,
	output logic clear_b
);

	// ********************
	// arithmetic helpers
	// ********************

	// clamp a written multiplier into the legal magnitude band
	function automatic mult_t clamp_mult(input logic signed [31:0] v);
		logic [32:0] mag;
		logic neg;
		neg = v[31];
		mag = neg ? 33'(-$signed({v[31], v})) : {1'b0, v};
		if (mag > `MULT_MAX)
			mag = `MULT_MAX;
		// zero is no legal multiplier, it becomes the smallest step
		if (mag < `MULT_MIN)
			mag = `MULT_MIN;
		clamp_mult = neg ? -$signed(mag[31:0]) : $signed(mag[31:0]);
	endfunction

	// saturate a sign plus 34-bit magnitude into the offset range
	function automatic ofs_t sat_ofs(input logic neg, input logic [33:0] mag);
		logic [33:0] m;
		// symmetric range: the minimum is the negated maximum
		m = (mag > `OFS_MAX) ? `OFS_MAX : mag;
		sat_ofs = neg ? -$signed(m[31:0]) : $signed(m[31:0]);
	endfunction

	// (count + offset) * multiplier, all in micro units
	function automatic scaled_t scale(input ofs_t cnt, input ofs_t ofs,
		input mult_t m);
		logic signed [32:0] sum;
		scaled_t s64;
		scaled_t m64;
		sum = 33'(cnt) + 33'(ofs);
		s64 = 64'(sum);
		m64 = 64'(m);
		// a 33-bit sum by a 32-bit multiplier cannot overflow 64 bits
		scale = s64 * m64;
	endfunction

	// ********************
	// state
	// ********************
	// index clear state
	logic [1:0] armed_r;
	logic [1:0] armed_nxt;
	logic [1:0] edge_rise_r;
	logic [1:0] edge_rise_nxt;
	logic [1:0] idx_prev_r;
	logic [1:0] clear_r;
	// channel parameters
	logic [2:0] cfg_r [2];
	mult_t mult_r [2];
	ofs_t ofs_r [2];
	logic [2:0] ofs_hi_r;
	// scaled readout
	scaled_t scaled_r [2];
	logic [31:0] snap_hi_r [2];
	// bus reply
	logic [31:0] rdata_r;

	// ********************
	// address and write decode
	// ********************

	// exact match of the bus address against one register offset
	function automatic logic addr_is(input logic [7:0] a,
		input logic [7:0] off);
		addr_is = (a == off);
	endfunction

	// one match per register, shared by write and read decode
	wire hit_cmd = addr_is(addr, `ADDR_CMD);
	wire hit_cfg_a = addr_is(addr, `ADDR_CFG_A);
	wire hit_cfg_b = addr_is(addr, `ADDR_CFG_B);
	wire hit_mult_a = addr_is(addr, `ADDR_MULT_A);
	wire hit_mult_b = addr_is(addr, `ADDR_MULT_B);
	wire hit_ofs_hi = addr_is(addr, `ADDR_OFS_HI);
	wire hit_ofs_a = addr_is(addr, `ADDR_OFS_A);
	wire hit_ofs_b = addr_is(addr, `ADDR_OFS_B);
	wire hit_scl_a_lo = addr_is(addr, `ADDR_SCL_A_LO);
	wire hit_scl_a_hi = addr_is(addr, `ADDR_SCL_A_HI);
	wire hit_scl_b_lo = addr_is(addr, `ADDR_SCL_B_LO);
	wire hit_scl_b_hi = addr_is(addr, `ADDR_SCL_B_HI);
	wire hit_zmode_a = addr_is(addr, `ADDR_ZMODE_A);
	wire hit_zmode_b = addr_is(addr, `ADDR_ZMODE_B);
	wire hit_set_a = addr_is(addr, `ADDR_SET_A);
	wire hit_set_b = addr_is(addr, `ADDR_SET_B);

	// command fields; only the named channel is touched
	wire wr_cmd = wr_en && hit_cmd;
	wire index_op_t op = index_op_t'(wdata[`CMD_OP_MSB:`CMD_OP_LSB]);
	wire op_ch = wdata[`CMD_CHAN_BIT];
	wire [1:0] ch_sel = op_ch ? 2'h2 : 2'h1;
	wire [1:0] arm_w = (wr_cmd && op == OP_ARM) ? ch_sel : 2'h0;
	wire [1:0] cancel_w = (wr_cmd && op == OP_CANCEL) ? ch_sel : 2'h0;
	wire [1:0] edge_w = (wr_cmd && op == OP_EDGE) ? ch_sel : 2'h0;
	wire wr_cfg_a = wr_en && hit_cfg_a;
	wire wr_cfg_b = wr_en && hit_cfg_b;
	wire wr_mult_a = wr_en && hit_mult_a;
	wire wr_mult_b = wr_en && hit_mult_b;
	wire wr_ofs_hi = wr_en && hit_ofs_hi;
	wire wr_ofs_a = wr_en && hit_ofs_a;
	wire wr_ofs_b = wr_en && hit_ofs_b;
	wire rd_lo_a = rd_en && hit_scl_a_lo;
	wire rd_lo_b = rd_en && hit_scl_b_lo;

	// ********************
	// index edge detection and clear
	// ********************
	// index pins are taken as clock-aligned; no synchroniser here
	wire [1:0] idx_now = {index_b, index_a};
	wire [1:0] idx_rise = idx_now & ~idx_prev_r;
	wire [1:0] idx_fall = ~idx_now & idx_prev_r;
	// armed channel fires on its chosen edge only
	wire [1:0] idx_hit = armed_r & ((edge_rise_r & idx_rise) |
		(~edge_rise_r & idx_fall));
	// a fresh arm beats a hit or cancel landing in the same cycle
	assign armed_nxt = arm_w | (armed_r & ~idx_hit & ~cancel_w);
	// edge letter U sets rising, D sets falling
	assign edge_rise_nxt = (edge_rise_r & ~edge_w) |
		(edge_w & {2{wdata[`CMD_EDGE_BIT]}});

	// index and clear flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			armed_r <= 2'h0;
			edge_rise_r <= {2{`EDGE_RISE_RESET}};
			idx_prev_r <= 2'h0;
			clear_r <= 2'h0;
		end else begin
			armed_r <= armed_nxt;
			edge_rise_r <= edge_rise_nxt;
			idx_prev_r <= idx_now;
			clear_r <= idx_hit;
		end
	end

	// clears leave straight from a flop, so they never glitch
	assign clear_a = clear_r[0];
	assign clear_b = clear_r[1];

	// ********************
	// settings and scaling parameters
	// ********************

	// offset magnitude above 32 bits is staged first, low word commits
	wire [33:0] ofs_mag = {ofs_hi_r[1:0], wdata};
	wire ofs_neg = ofs_hi_r[`OFS_HI_SIGN_BIT];

	// settings and multipliers; reset gives an unscaled readout
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_r[0] <= `CFG_RESET;
			cfg_r[1] <= `CFG_RESET;
			mult_r[0] <= `MULT_RESET;
			mult_r[1] <= `MULT_RESET;
		end else begin
			if (wr_cfg_a)
				cfg_r[0] <= wdata[2:0];
			if (wr_cfg_b)
				cfg_r[1] <= wdata[2:0];
			if (wr_mult_a)
				mult_r[0] <= clamp_mult(wdata);
			if (wr_mult_b)
				mult_r[1] <= clamp_mult(wdata);
		end
	end

	// offsets; the staged high bits stay until rewritten
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ofs_r[0] <= `OFS_RESET;
			ofs_r[1] <= `OFS_RESET;
			ofs_hi_r <= 3'h0;
		end else begin
			if (wr_ofs_hi)
				ofs_hi_r <= wdata[2:0];
			if (wr_ofs_a)
				ofs_r[0] <= sat_ofs(ofs_neg, ofs_mag);
			if (wr_ofs_b)
				ofs_r[1] <= sat_ofs(ofs_neg, ofs_mag);
		end
	end

	// scaled values trail the counts by one cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scaled_r[0] <= 64'sh0;
			scaled_r[1] <= 64'sh0;
		end else begin
			scaled_r[0] <= scale(count_a, ofs_r[0], mult_r[0]);
			scaled_r[1] <= scale(count_b, ofs_r[1], mult_r[1]);
		end
	end

	// reading the low word freezes the high word, so halves never tear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			snap_hi_r[0] <= 32'h0;
			snap_hi_r[1] <= 32'h0;
		end else begin
			if (rd_lo_a)
				snap_hi_r[0] <= scaled_r[0][63:32];
			if (rd_lo_b)
				snap_hi_r[1] <= scaled_r[1][63:32];
		end
	end

	// ********************
	// query replies
	// ********************

	// edge multiplication digit of a setting
	function automatic logic [7:0] mult_chr(input logic [1:0] code);
		mult_chr = (code == EDGE_X4) ? `CHR_4 :
			(code == EDGE_X2) ? `CHR_2 : `CHR_1;
	endfunction

	// mode reply: Z, channel letter, armed C or N, edge U or D
	function automatic logic [31:0] zmode_word(input logic [7:0] letter,
		input logic armed, input logic rise);
		zmode_word = {`CHR_Z, letter, armed ? `CHR_C : `CHR_N,
			rise ? `CHR_U : `CHR_D};
	endfunction

	// setting reply: multiplication digit, then F or R
	function automatic logic [31:0] set_word(input logic [2:0] cfg);
		set_word = {16'h0, mult_chr(cfg[`CFG_MULT_MSB:`CFG_MULT_LSB]),
			cfg[`CFG_DIR_BIT] ? `CHR_R : `CHR_F};
	endfunction

	wire [31:0] zmode_a = zmode_word(`CHR_A, armed_r[0],
		edge_rise_r[0]);
	wire [31:0] zmode_b = zmode_word(`CHR_B, armed_r[1],
		edge_rise_r[1]);
	wire [31:0] set_a = set_word(cfg_r[0]);
	wire [31:0] set_b = set_word(cfg_r[1]);
	wire [31:0] cmd_stat = {28'h0, edge_rise_r, armed_r};

	// ********************
	// read select; unmapped reads answer zero
	// ********************
	wire [31:0] rd_sel =
		hit_cmd ? cmd_stat :
		hit_cfg_a ? {29'h0, cfg_r[0]} :
		hit_cfg_b ? {29'h0, cfg_r[1]} :
		hit_mult_a ? 32'(mult_r[0]) :
		hit_mult_b ? 32'(mult_r[1]) :
		hit_ofs_hi ? {29'h0, ofs_hi_r} :
		hit_ofs_a ? ofs_r[0] :
		hit_ofs_b ? ofs_r[1] :
		hit_scl_a_lo ? scaled_r[0][31:0] :
		hit_scl_a_hi ? snap_hi_r[0] :
		hit_scl_b_lo ? scaled_r[1][31:0] :
		hit_scl_b_hi ? snap_hi_r[1] :
		hit_zmode_a ? zmode_a :
		hit_zmode_b ? zmode_b :
		hit_set_a ? set_a :
		hit_set_b ? set_b : 32'h0;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rdata_r <= 32'h0;
		else
			rdata_r <= rd_en ? rd_sel : 32'h0;
	end

	assign rdata = rdata_r;

endmodule

//--- enc_zscale_props.sv
// assertions for the encoder index-clear and scaling block
`include "enc_zscale_consts.svh"
module enc_zscale_props (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic rd_en,
	input wire logic [31:0] rdata,
	// index side
	input wire logic index_a,
	input wire logic index_b,
	input wire logic clear_a,
	input wire logic clear_b
);
	// ****
	// checks
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
		else $error("rdata not zero outside read");
	// a pulse needs an index change one cycle earlier
	clr_a_edge_a: assert property (
		clear_a |-> $past(index_a) != $past(index_a, 2))
		else $error("clear_a without index edge");
	clr_b_edge_a: assert property (
		clear_b |-> $past(index_b) != $past(index_b, 2))
		else $error("clear_b without index edge");
	zmode_reply_a: assert property (rd_en && addr == `ADDR_ZMODE_A
		|=> rdata[31:16] == 16'h5a41 && rdata[15:8] inside {8'h43, 8'h4e}
		&& rdata[7:0] inside {8'h55, 8'h44})
		else $error("bad mode reply");
	zmode_b_reply_a: assert property (rd_en && addr == `ADDR_ZMODE_B
		|=> rdata[31:16] == 16'h5a42 && rdata[15:8] inside {8'h43, 8'h4e}
		&& rdata[7:0] inside {8'h55, 8'h44})
		else $error("bad channel b mode reply");
	set_reply_a: assert property (rd_en && addr == `ADDR_SET_B
		|=> rdata[31:16] == 16'h0 && rdata[7:0] inside {8'h46, 8'h52})
		else $error("bad setting reply");
	mult_range_a: assert property (rd_en && addr == `ADDR_MULT_A
		|=> rdata != 32'h0 && $signed(rdata) <= 999999999
		&& $signed(rdata) >= -999999999)
		else $error("multiplier out of range");
	ofs_limit_a: assert property (rd_en && addr == `ADDR_OFS_B
		|=> rdata != 32'h80000000)
		else $error("offset beyond limit");
	unmapped_zero_a: assert property (rd_en && addr > 8'h3c |=> rdata == 0)
		else $error("unmapped read not zero");
	cover property (clear_a);
	cover property (clear_b);
	cover property (rd_en && addr == `ADDR_SCL_A_LO);
endmodule

bind enc_zscale enc_zscale_props i_enc_zscale_props (.clock(clock),
	.rst(rst), .addr(addr), .rd_en(rd_en), .rdata(rdata),
	.index_a(index_a), .index_b(index_b), .clear_a(clear_a),
	.clear_b(clear_b));

//--- enc_far_model.sv
// encoder counter model: presets on load, empties on a clear pulse
module enc_far_model (
	// clock
	input wire logic clock,
	// from the block and the bench
	input wire logic clear_a,
	input wire logic clear_b,
	input wire logic load,
	input wire logic signed [31:0] load_val,
	// raw counts
	output logic signed [31:0] count_a = 32'sh0,
	output logic signed [31:0] count_b = 32'sh0
);
	timeunit 1ns;
	timeprecision 1ps;
	// clear wins over load, like a real counter reset
	always @(posedge clock) begin
		if (clear_a) count_a <= 32'sh0;
		else if (load) count_a <= load_val;
		if (clear_b) count_b <= 32'sh0;
		else if (load) count_b <= load_val;
	end
endmodule

//--- enc_zscale_tb_top.sv
// testbench for the encoder index-clear and scaling block
`include "enc_zscale_consts.svh"
module enc_zscale_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, wr_en = 0, rd_en = 0, load = 0;
	logic index_a = 0, index_b = 0, clear_a, clear_b;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic signed [31:0] count_a, count_b, ld_v = 32'sh0;
	logic signed [63:0] e;
	logic [7:0] dig [3] = '{8'h31, 8'h32, 8'h34};
	int fails = 0, cmp_count = 0;
	always #2 clock = ~clock;
	enc_zscale i_enc_zscale (.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.count_a(count_a), .count_b(count_b), .index_a(index_a),
		.index_b(index_b), .clear_a(clear_a), .clear_b(clear_b));
	enc_far_model i_enc_far_model (.clock(clock), .clear_a(clear_a),
		.clear_b(clear_b), .load(load), .load_val(ld_v),
		.count_a(count_a), .count_b(count_b));
	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// strobe falls after one edge, so calls never collide
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		#20000;
		fails++;
		final_report;
	end
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(`ADDR_MULT_A, 32'd1000000);
		rd(`ADDR_OFS_B, 32'h0);
		rd(`ADDR_ZMODE_B, 32'h5a424e55);
		rd(8'h40, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			wr(`ADDR_CFG_A, 32'(i % 3 + i / 3 * 4));
			rd(`ADDR_SET_A, {16'h0, dig[i % 3], i < 3 ? 8'h46 : 8'h52});
		end
		rd(`ADDR_CFG_A, 32'h6);
		rd(`ADDR_SET_B, 32'h00003146);
		wr(`ADDR_CFG_B, 32'h2);
		rd(`ADDR_SET_B, 32'h00003446);
		$display("setting test done");
		wr(`ADDR_MULT_A, 32'h0);
		rd(`ADDR_MULT_A, 32'd1);
		wr(`ADDR_MULT_A, 32'd2000000000);
		rd(`ADDR_MULT_A, 32'd999999999);
		wr(`ADDR_MULT_B, -32'sd2000000);
		rd(`ADDR_MULT_B, -32'sd2000000);
		wr(`ADDR_OFS_HI, 32'h7);
		wr(`ADDR_OFS_A, 32'h0);
		rd(`ADDR_OFS_A, 32'h80000001);
		wr(`ADDR_OFS_HI, 32'h1);
		wr(`ADDR_OFS_A, 32'h0);
		rd(`ADDR_OFS_A, 32'h7fffffff);
		wr(`ADDR_OFS_HI, 32'h4);
		wr(`ADDR_OFS_B, 32'd10);
		rd(`ADDR_OFS_B, -32'sd10);
		// preset both counters, then read scaled values
		@(posedge clock) ld_v <= 32'sd1000;
		load <= 1'b1;
		@(posedge clock) load <= 1'b0;
		e = 64'sd990 * -64'sd2000000;
		rd(`ADDR_SCL_B_LO, e[31:0]);
		rd(`ADDR_SCL_B_HI, e[63:32]);
		e = 64'sd2147484647 * 64'sd999999999;
		rd(`ADDR_SCL_A_LO, e[31:0]);
		rd(`ADDR_SCL_A_HI, e[63:32]);
		$display("scaling test done");
		wr(`ADDR_CMD, 32'h0);
		rd(`ADDR_ZMODE_A, 32'h5a414355);
		@(posedge clock) index_a <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk(count_a, 32'h0);
		rd(`ADDR_ZMODE_A, 32'h5a414e55);
		wr(`ADDR_CMD, 32'h4);
		wr(`ADDR_CMD, 32'h5);
		@(posedge clock) index_b <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk(count_b, 32'd1000);
		// channel A is at x4, so falling edge select is allowed; the block accepts it in any setting
		@(posedge clock) load <= 1'b1;
		@(posedge clock) load <= 1'b0;
		wr(`ADDR_CMD, 32'h2);
		wr(`ADDR_CMD, 32'h0);
		rd(`ADDR_ZMODE_A, 32'h5a414344);
		@(posedge clock) index_a <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk(count_a, 32'h0);
		// channel B: a rising index after arming empties its counter
		@(posedge clock) index_b <= 1'b0;
		wr(`ADDR_CMD, 32'h4);
		rd(`ADDR_CMD, 32'ha);
		@(posedge clock) index_b <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk(count_b, 32'h0);
		$display("index test done");
		final_report;
	end
endmodule
